// [spr_dev.sv]
// device end: serial slave giving access to 64 registers of 16 bits
`timescale 1ns/10ps
`default_nettype none
// How it works
// [RULE_01] device is slave; master makes every clock
// [RULE_02] data output floats unless shifting read data
// [RULE_03] six address bits, sixteen-bit registers
// [RULE_04] polarity strap picks clock idle level
// [RULE_05] phase strap picks sample and update edges
// [RULE_06] no clock needed while deselected
// [RULE_07] deselect floats output, drops partial transfer
// [RULE_08] select falling edge starts a transaction
// [RULE_09] control word: direction, address, burst bit
// [RULE_10] direction 1 reads; burst 1 bursts
// [RULE_11] data msb first, lsb first when swapped
// [RULE_12] single write lands after last bit
// [RULE_13] single read returns word; then new control
// [RULE_14] burst write stores, then advances address
// [RULE_15] burst address wraps from 1Fh to 00h
// [RULE_16] burst read advances and prefetches next word
// [RULE_17] master ends burst by raising select
// [RULE_18] master avoids ending before latched status
// [RULE_19] early deselect resets the serial logic
// [RULE_20] aborted write leaves register unchanged
// [RULE_21] tied lines: master releases during read data
// [RULE_22] tied lines: deselect between commands
// [RULE_23] serial rate scales with internal clock
// [RULE_24] inputs synchronised; registers seen as strobes
module spr_dev
  import spr_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              clkEn,
  // straps
  input  wire logic              cpolStrap,
  input  wire logic              cphaStrap,
  input  wire logic              bitOrderReverseStrap,
  // serial link
  spr_link_if.dev                link,
  // register access
  output logic                   regWr,
  output logic                   regRd,
  output logic [ADDR_W-1:0]      regAddr,
  output logic [DATA_W-1:0]      regWrData,
  input  wire logic [DATA_W-1:0] regRdData
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [5:0]        inS1;
    logic [5:0]        inS2;
    logic              sclkD;
    spr_dst_t          st;
    logic [4:0]        bitCnt;
    logic [DATA_W-1:0] rxSr;
    logic [DATA_W-1:0] txSr;
    logic              isRead;
    logic              isBurst;
    logic [ADDR_W-1:0] addr;
    logic              rdPend;
    logic              outData;
    logic              outOe;
    logic              regWr;
    logic              regRd;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
  } spr_dev_state_t;

  spr_dev_state_t s;
  spr_dev_state_t next_s;

  // ==========================================================
  // decode helpers
  logic              sclkNow;
  logic              cpol;
  logic              cpha;
  logic              swap;
  logic              serial_in_line;
  logic              leadEv;
  logic              trailEv;
  logic              sampleEv;
  logic              shiftEv;
  logic [CTRL_W-1:0] ctrlWord;
  logic [ADDR_W-1:0] addrRaw;
  logic [ADDR_W-1:0] addrRev;
  logic [ADDR_W-1:0] addrInc;
  logic [DATA_W-1:0] rxNext;

  // only the second stage of each synchroniser is read
  assign sclkNow = s.inS2[IN_SCLK]; // RULE_01
  assign cpol    = s.inS2[IN_CPOL];
  assign cpha    = s.inS2[IN_CPHA];
  assign swap    = s.inS2[IN_SWAP];
  assign serial_in_line     = s.inS2[IN_SDI];

  // edges seen against the idle level
  assign leadEv   = (s.sclkD == cpol) && (sclkNow != cpol); // RULE_04
  assign trailEv  = (s.sclkD != cpol) && (sclkNow == cpol); // RULE_04
  assign sampleEv = cpha ? trailEv : leadEv; // RULE_05
  assign shiftEv  = cpha ? leadEv : trailEv; // RULE_05

  assign ctrlWord = {s.rxSr[CTRL_W-2:0], serial_in_line};
  assign addrRaw  = ctrlWord[CTRL_DIR_POS-1:CTRL_BURST_POS+1];

  // address bits arrive reversed under the swap strap
  for (genvar i = 0; i < ADDR_W; i++) begin : g_addr_rev
    assign addrRev[i] = addrRaw[ADDR_W-1-i]; // RULE_09
  end

  // burst pointer folds back after 1Fh
  assign addrInc = (s.addr == BURST_WRAP_ADDR) ? ADDR_FIRST : ADDR_W'(s.addr + 1'b1); // RULE_15

  // data shifts in from the end that goes last
  assign rxNext = swap ? {serial_in_line, s.rxSr[DATA_W-1:1]} : {s.rxSr[DATA_W-2:0], serial_in_line}; // RULE_11

  // ==========================================================
  // next state
  always_comb begin
    next_s        = s;
    next_s.inS1   = {link.sclk, link.csN, link.serialInLine,
                     cpolStrap, cphaStrap, bitOrderReverseStrap}; // RULE_24
    next_s.inS2   = s.inS1; // RULE_24 RULE_23
    next_s.sclkD  = sclkNow;
    next_s.regWr  = 1'b0;
    next_s.regRd  = 1'b0;

    // read data stands only in the cycle after the strobe
    next_s.rdPend = s.regRd; // RULE_24
    if (s.rdPend) begin
      next_s.txSr = regRdData; // RULE_13 RULE_16
    end

    if (s.inS2[IN_CSN]) begin
      // no clock edge is needed to get back to idle
      next_s.st     = DS_IDLE; // RULE_07 RULE_19 RULE_06
      next_s.outOe  = 1'b0; // RULE_07
      next_s.bitCnt = BIT_CNT_ZERO; // RULE_20
    end else begin
      unique case (s.st)
        DS_IDLE: begin
          next_s.st     = DS_CTRL; // RULE_08
          next_s.bitCnt = BIT_CNT_ZERO;
        end
        DS_CTRL: begin
          if (sampleEv) begin
            next_s.rxSr   = {s.rxSr[DATA_W-2:0], serial_in_line};
            next_s.bitCnt = 5'(s.bitCnt + 1'b1);
            if (s.bitCnt == CTRL_LAST_BIT) begin
              next_s.bitCnt  = BIT_CNT_ZERO;
              next_s.isRead  = ctrlWord[CTRL_DIR_POS]; // RULE_10
              next_s.isBurst = ctrlWord[CTRL_BURST_POS]; // RULE_10
              next_s.addr    = swap ? addrRev : addrRaw; // RULE_09 RULE_03
              if (ctrlWord[CTRL_DIR_POS]) begin
                next_s.st      = DS_RD;
                next_s.regRd   = 1'b1; // RULE_13
                next_s.regAddr = swap ? addrRev : addrRaw;
              end else begin
                next_s.st = DS_WR;
              end
            end
          end
        end
        DS_WR: begin
          if (sampleEv) begin
            next_s.rxSr   = rxNext;
            next_s.bitCnt = 5'(s.bitCnt + 1'b1);
            // nothing is stored before the final bit
            if (s.bitCnt == DATA_LAST_BIT) begin
              next_s.bitCnt    = BIT_CNT_ZERO;
              next_s.regWr     = 1'b1; // RULE_12 RULE_20 RULE_24
              next_s.regAddr   = s.addr; // RULE_14
              next_s.regWrData = rxNext;
              if (s.isBurst) begin
                next_s.addr = addrInc; // RULE_14
              end else begin
                next_s.st = DS_CTRL; // RULE_13
              end
            end
          end
        end
        DS_RD: begin
          if (shiftEv) begin
            next_s.outOe   = 1'b1; // RULE_02
            next_s.outData = swap ? s.txSr[0] : s.txSr[DATA_W-1]; // RULE_11
            next_s.txSr    = swap ? {1'b0, s.txSr[DATA_W-1:1]}
                                  : {s.txSr[DATA_W-2:0], 1'b0};
          end
          if (sampleEv) begin
            next_s.bitCnt = 5'(s.bitCnt + 1'b1);
            if (s.bitCnt == DATA_LAST_BIT) begin
              // release as soon as the master has taken the last bit
              next_s.outOe  = 1'b0; // RULE_02
              next_s.bitCnt = BIT_CNT_ZERO;
              if (s.isBurst) begin
                // the prefetch reads the next register even if never sent
                next_s.addr    = addrInc; // RULE_16 RULE_15
                next_s.regRd   = 1'b1; // RULE_16
                next_s.regAddr = addrInc;
              end else begin
                next_s.st = DS_CTRL; // RULE_13
              end
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s      <= '0;
      s.st   <= DS_IDLE;
      s.inS1 <= IN_RESET;
      s.inS2 <= IN_RESET;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign link.serialOutLine = s.outData;
  assign link.serialOutOe   = s.outOe;
  assign regWr              = s.regWr;
  assign regRd              = s.regRd;
  assign regAddr            = s.regAddr;
  assign regWrData          = s.regWrData;

endmodule
`default_nettype wire

// [spr_host.sv]
// host end: serial master issuing single and burst register transfers
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module spr_host
  import spr_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
)(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              clkEn,
  // link mode, must match the device straps
  input  wire logic              cpol,
  input  wire logic              cpha,
  input  wire logic              bitOrderReverseStrap,
  // command
  input  wire logic              cmdStart,
  input  wire logic              cmdRead,
  input  wire logic              cmdBurst,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [7:0]        cmdWords,
  input  wire logic [DATA_W-1:0] wrData,
  // status
  output logic                   busy,
  output logic                   wrNext,
  output logic                   rdValid,
  output logic [DATA_W-1:0]      rdData,
  // serial link
  spr_link_if.host               link
);

  // slower edges leave room for both synchronisers
  if (HALF_CYC < MIN_HALF_CYC || HALF_CYC > MAX_HALF_CYC) begin : g_check
    $error("spr_host: HALF_CYC out of range"); // RULE_23
  end

  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

  // ==========================================================
  // state
  typedef struct packed {
    spr_hst_t          st;
    logic [7:0]        halfCnt;
    logic              sclk;
    logic              csN;
    logic              dOut;
    logic              dOe;
    logic              lead;
    logic [4:0]        bitCnt;
    logic              inCtrl;
    logic              isRead;
    logic              cpha;
    logic              lsbFirst;
    logic              idleLvl;
    logic [7:0]        wordsLeft;
    logic [DATA_W-1:0] txSr;
    logic [DATA_W-1:0] rxSr;
    logic              misoS1;
    logic              misoS2;
    logic              busy;
    logic              wrNext;
    logic              rdValid;
    logic [DATA_W-1:0] rdData;
  } spr_host_state_t;

  spr_host_state_t s;
  spr_host_state_t next_s;

  logic [ADDR_W-1:0] addrRev;
  logic [CTRL_W-1:0] ctrlWord;
  logic              tick;
  logic              sampleEv;
  logic              driveEv;
  logic              bitLsb;
  logic [DATA_W-1:0] rxNext;

  for (genvar i = 0; i < ADDR_W; i++) begin : g_addr_rev
    assign addrRev[i] = cmdAddr[ADDR_W-1-i]; // RULE_09
  end

  assign ctrlWord = {cmdRead, bitOrderReverseStrap ? addrRev : cmdAddr, cmdBurst}; // RULE_09
  assign tick     = (s.halfCnt == HALF_M1);
  assign sampleEv = tick && (s.lead != s.cpha); // RULE_05
  assign driveEv  = tick && (s.lead == s.cpha); // RULE_05
  assign bitLsb   = s.lsbFirst && !s.inCtrl;
  assign rxNext   = bitLsb ? {s.misoS2, s.rxSr[DATA_W-1:1]} : {s.rxSr[DATA_W-2:0], s.misoS2};

  // ==========================================================
  // next state
  always_comb begin
    next_s         = s;
    next_s.misoS1  = link.masterInLine;
    next_s.misoS2  = s.misoS1;
    next_s.wrNext  = 1'b0;
    next_s.rdValid = 1'b0;
    next_s.halfCnt = tick ? 8'h00 : 8'(s.halfCnt + 1'b1);

    unique case (s.st)
      HS_IDLE: begin
        next_s.sclk    = cpol; // RULE_04 RULE_01
        next_s.csN     = 1'b1;
        next_s.halfCnt = 8'h00;
        if (cmdStart) begin
          next_s.st        = HS_RUN;
          next_s.csN       = 1'b0; // RULE_08
          next_s.dOe       = 1'b1;
          next_s.busy      = 1'b1;
          next_s.lead      = 1'b1;
          next_s.inCtrl    = 1'b1;
          next_s.bitCnt    = BIT_CNT_ZERO;
          next_s.isRead    = cmdRead;
          next_s.cpha      = cpha;
          next_s.idleLvl   = cpol;
          next_s.lsbFirst  = bitOrderReverseStrap; // RULE_11
          // the caller's count sets where a burst stops
          next_s.wordsLeft = (cmdBurst && cmdWords != 8'h00) ? cmdWords : 8'h01; // RULE_18
          next_s.txSr      = {ctrlWord, 8'h00};
          // with phase 0 the first bit must lead the first edge
          if (!cpha) begin
            next_s.dOut = ctrlWord[CTRL_DIR_POS]; // RULE_05
            next_s.txSr = {ctrlWord[CTRL_W-2:0], 9'h000};
          end
        end
      end
      HS_RUN: begin
        if (tick) begin
          next_s.sclk = !s.sclk; // RULE_01
          next_s.lead = !s.lead;
        end
        if (driveEv && s.dOe) begin
          next_s.dOut = bitLsb ? s.txSr[0] : s.txSr[DATA_W-1]; // RULE_11
          next_s.txSr = bitLsb ? {1'b0, s.txSr[DATA_W-1:1]} : {s.txSr[DATA_W-2:0], 1'b0};
          // let go half a period after the last control bit, never on a sample edge
          if (s.isRead && !s.inCtrl) begin
            next_s.dOe = 1'b0; // RULE_21
          end
        end
        if (sampleEv) begin
          next_s.rxSr   = rxNext;
          next_s.bitCnt = 5'(s.bitCnt + 1'b1);
          if (s.inCtrl && s.bitCnt == CTRL_LAST_BIT) begin
            next_s.bitCnt = BIT_CNT_ZERO;
            next_s.inCtrl = 1'b0;
            if (!s.isRead) begin
              next_s.txSr   = wrData;
              next_s.wrNext = 1'b1;
            end
          end else if (!s.inCtrl && s.bitCnt == DATA_LAST_BIT) begin
            next_s.bitCnt    = BIT_CNT_ZERO;
            next_s.wordsLeft = 8'(s.wordsLeft - 1'b1);
            if (s.isRead) begin
              next_s.rdValid = 1'b1;
              next_s.rdData  = rxNext;
            end
            if (s.wordsLeft == 8'h01) begin
              next_s.st = HS_TAIL;
            end else if (!s.isRead) begin
              next_s.txSr   = wrData;
              next_s.wrNext = 1'b1;
            end
          end
        end
      end
      HS_TAIL: begin
        // one command per selection also suits tied data lines
        if (tick) begin
          // the last bit was held through its sample edge
          next_s.dOe = 1'b0;
          if (s.sclk != s.idleLvl) begin
            next_s.sclk = s.idleLvl; // RULE_04
          end else if (!s.csN) begin
            next_s.csN = 1'b1; // RULE_17 RULE_22
          end else begin
            next_s.st   = HS_IDLE;
            next_s.busy = 1'b0;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s     <= '0;
      s.st  <= HS_IDLE;
      s.csN <= 1'b1;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign link.sclk       = s.sclk;
  assign link.csN        = s.csN;
  assign link.hostData   = s.dOut;
  assign link.hostDataOe = s.dOe;
  assign busy            = s.busy;
  assign wrNext          = s.wrNext;
  assign rdValid         = s.rdValid;
  assign rdData          = s.rdData;

endmodule
`default_nettype wire

// [spr_link_checker.sv]
// assertions on the serial link between the host and device ends
`timescale 1ns/10ps
`default_nettype none
module spr_link_checker
  import spr_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // link and mode
  input  wire logic cpol,
  input  wire logic sclk,
  input  wire logic csN,
  input  wire logic hostDataOe,
  input  wire logic serialOutOe,
  // register strobes
  input  wire logic regWr,
  input  wire logic regRd
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // link
  AST_OE_DROPS_ON_DESELECT: assert property (csN [*5] |-> !serialOutOe)
    else $error("data output driven while deselected");
  AST_NO_CONTENTION: assert property (!(serialOutOe && hostDataOe))
    else $error("both ends drive the shared data line");
  AST_SCLK_IDLE: assert property ((csN && $stable(cpol)) [*3] |-> sclk == cpol)
    else $error("serial clock not at idle level between frames");
  AST_SCLK_AT_SELECT: assert property ($fell(csN) |-> sclk == cpol && $past(sclk) == cpol)
    else $error("serial clock not idle when select falls");
  AST_NO_DRIVE_IN_CONTROL: assert property ($fell(csN) |-> !serialOutOe [*8])
    else $error("device drives data during control word");

  // ==========================================================
  // register strobes
  AST_STROBE_SPACING: assert property ((regWr || regRd) |=> !(regWr || regRd) [*7])
    else $error("register strobes too close together");
  AST_STROBE_EXCLUSIVE: assert property (!(regWr && regRd))
    else $error("read and write strobe together");
  AST_QUIET_DESELECTED: assert property (csN [*6] |-> !regWr && !regRd)
    else $error("register access while deselected");

  cover property (regWr);
  cover property (regRd);
  cover property ($rose(serialOutOe));
  cover property ($rose(csN) ##1 csN [*2]);
endmodule
`default_nettype wire

// [spr_link_if.sv]
// serial link between the register port and its bus master
`timescale 1ns/10ps
`default_nettype none
interface spr_link_if;
  logic sclk;
  logic csN;
  logic hostData;
  logic hostDataOe;
  logic serialInLine;
  logic serialOutLine;
  logic serialOutOe;
  logic masterInLine;

  modport dev (
    input  sclk,
    input  csN,
    input  serialInLine,
    output serialOutLine,
    output serialOutOe
  );

  modport host (
    output sclk,
    output csN,
    output hostData,
    output hostDataOe,
    input  masterInLine
  );
endinterface
`default_nettype wire

// [spr_pkg.sv]
// shared constants and types for the serial register port
package spr_pkg;

  // ==========================================================
  // word layout
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 16;
  localparam int          CTRL_W          = 8;
  localparam int          CTRL_DIR_POS    = 7;
  localparam int          CTRL_BURST_POS  = 0;
  localparam logic [5:0]  ADDR_LAST       = 6'h3F;
  localparam logic [5:0]  ADDR_FIRST      = 6'h00;
  localparam logic [5:0]  BURST_WRAP_ADDR = 6'h1F;
  localparam logic [4:0]  CTRL_LAST_BIT   = 5'h07;
  localparam logic [4:0]  DATA_LAST_BIT   = 5'h0F;
  localparam logic [4:0]  BIT_CNT_ZERO    = 5'h00;

  // ==========================================================
  // positions inside the device input synchroniser
  localparam int IN_SCLK = 5;
  localparam int IN_CSN  = 4;
  localparam int IN_SDI  = 3;
  localparam int IN_CPOL = 2;
  localparam int IN_CPHA = 1;
  localparam int IN_SWAP = 0;
  localparam logic [5:0] IN_RESET = 6'h10;

  // ==========================================================
  // timing
  localparam int CORE_CLK_MHZ     = 100;
  localparam int REF_CLK_MHZ      = 125;
  localparam int SCLK_MAX_MHZ     = 25;
  localparam int SCLK_SCALED_KHZ  = SCLK_MAX_MHZ * 1000 * CORE_CLK_MHZ / REF_CLK_MHZ;
  localparam int LINK_HALF_NS     = 80;
  localparam int LINK_HALF_CYC    = (LINK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int MIN_HALF_CYC     = 8;
  localparam int MAX_HALF_CYC     = 255;

  // ==========================================================
  // state encodings
  typedef enum logic [3:0] {
    DS_IDLE = 4'h1,
    DS_CTRL = 4'h2,
    DS_WR   = 4'h4,
    DS_RD   = 4'h8
  } spr_dst_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_RUN  = 3'h2,
    HS_TAIL = 3'h4
  } spr_hst_t;

endpackage

// [tb_top.sv]
// self-checking bench joining host and device ends over the serial link
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import spr_pkg::*;
;
  // mode bits: cpol, cpha, swap, read, burst
  typedef struct packed {
    logic [4:0]  mode;
    logic [5:0]  addr;
    logic [7:0]  words;
    logic [15:0] data;
  } spr_row_t;

  localparam spr_row_t ROWS [10] = '{
    '{5'h00, 6'h05, 8'h01, 16'h1234}, '{5'h02, 6'h05, 8'h01, 16'h0000},
    '{5'h08, 6'h2A, 8'h01, 16'hA5C3}, '{5'h16, 6'h2A, 8'h01, 16'h0000},
    '{5'h1C, 6'h3F, 8'h01, 16'h8001}, '{5'h1A, 6'h3F, 8'h01, 16'h0000},
    '{5'h0D, 6'h1E, 8'h04, 16'hC000}, '{5'h13, 6'h1E, 8'h04, 16'h0000},
    '{5'h01, 6'h3F, 8'h02, 16'h7700}, '{5'h1F, 6'h3F, 8'h02, 16'h0000}};

  logic        core_clk  = 1'b0;
  logic        srst      = 1'b1;
  logic        hostAbort = 1'b0;
  logic        cpolSel   = 1'b0;
  logic        cphaSel   = 1'b0;
  logic        swapSel   = 1'b0;
  logic        cmdStart  = 1'b0;
  logic        cmdRead   = 1'b0;
  logic        cmdBurst  = 1'b0;
  logic [5:0]  cmdAddr   = 6'h00;
  logic [7:0]  cmdWords  = 8'h00;
  logic [15:0] wrData    = 16'h0000;
  logic [15:0] regRdData = 16'h0000;
  logic        regWr;
  logic        regRd;
  logic [5:0]  regAddr;
  logic [15:0] regWrData;
  logic        busy;
  logic        wrNext;
  logic        rdValid;
  logic [15:0] rdData;
  logic [15:0] mem [64];
  logic [15:0] expMem [64];
  logic [15:0] rdQ [$];
  logic        prevSclk  = 1'b0;
  logic        prevCs    = 1'b1;
  logic [31:0] cap       = 32'h0;
  logic [7:0]  ctrlSeen  = 8'h00;
  int          bitCnt    = 0;
  int          wrCnt     = 0;
  int          failCount = 0;
  int          comparisons = 0;

  always #5 core_clk = ~core_clk;

  spr_link_if u_spr_link_if ();
  // tied data line with pull-up
  assign u_spr_link_if.serialInLine = u_spr_link_if.hostDataOe ? u_spr_link_if.hostData :
      (u_spr_link_if.serialOutOe ? u_spr_link_if.serialOutLine : 1'b1);
  assign u_spr_link_if.masterInLine = u_spr_link_if.serialInLine;

  spr_dev u_spr_dev (.core_clk(core_clk), .srst(srst), .clkEn(1'b1),
    .cpolStrap(cpolSel), .cphaStrap(cphaSel), .bitOrderReverseStrap(swapSel),
    .link(u_spr_link_if.dev), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));

  spr_host #(.HALF_CYC(8)) u_spr_host (.core_clk(core_clk), .srst(srst | hostAbort),
    .clkEn(1'b1), .cpol(cpolSel), .cpha(cphaSel), .bitOrderReverseStrap(swapSel),
    .cmdStart(cmdStart), .cmdRead(cmdRead), .cmdBurst(cmdBurst), .cmdAddr(cmdAddr),
    .cmdWords(cmdWords), .wrData(wrData), .busy(busy), .wrNext(wrNext),
    .rdValid(rdValid), .rdData(rdData), .link(u_spr_link_if.host));

  spr_link_checker u_spr_link_checker (.core_clk(core_clk), .srst(srst), .cpol(cpolSel),
    .sclk(u_spr_link_if.sclk), .csN(u_spr_link_if.csN),
    .hostDataOe(u_spr_link_if.hostDataOe), .serialOutOe(u_spr_link_if.serialOutOe),
    .regWr(regWr), .regRd(regRd));

  // ==========================================================
  // register file; off-cycle read data inverted to catch late sampling
  always @(posedge core_clk) begin
    if (regWr === 1'b1) begin
      mem[regAddr] <= regWrData;
      wrCnt <= wrCnt + 1;
    end
    regRdData <= (regRd === 1'b1) ? mem[regAddr] : ~mem[regAddr];
    if (rdValid === 1'b1) rdQ.push_back(rdData);
    if (wrNext === 1'b1) wrData <= wrData + 16'h0001;
  end

  // ==========================================================
  // wire monitor: bits taken at the sampling edge
  always @(posedge core_clk) begin
    prevSclk <= u_spr_link_if.sclk;
    prevCs <= u_spr_link_if.csN;
    if (u_spr_link_if.csN === 1'b0 && prevCs === 1'b1) begin
      bitCnt <= 0;
    end else if (u_spr_link_if.csN === 1'b0 && u_spr_link_if.sclk !== prevSclk &&
        ((u_spr_link_if.sclk !== cpolSel) !== cphaSel)) begin
      cap <= {cap[30:0], u_spr_link_if.serialInLine};
      bitCnt <= bitCnt + 1;
      if (bitCnt == 7) ctrlSeen <= {cap[6:0], u_spr_link_if.serialInLine};
    end
  end

  // ==========================================================
  // tasks
  function automatic logic [15:0] rev(input logic [15:0] v, input int n);
    logic [15:0] r;
    r = 16'h0000;
    for (int j = 0; j < n; j++) r[j] = v[n-1-j];
    return r;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      failCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic endOfTest;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // straps change only while deselected
  task automatic startCmd(input spr_row_t row);
    rdQ.delete();
    @(posedge core_clk);
    {cpolSel, cphaSel, swapSel} <= row.mode[4:2];
    repeat (6) @(posedge core_clk);
    cmdStart <= 1'b1;
    {cmdRead, cmdBurst} <= row.mode[1:0];
    cmdAddr <= row.addr;
    cmdWords <= row.words;
    wrData <= row.data;
    @(posedge core_clk);
    cmdStart <= 1'b0;
  endtask

  task automatic waitIdle;
    int k;
    k = 0;
    @(negedge core_clk);
    while (busy !== 1'b0 && k < 4000) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 4000) failCount++;
    repeat (4) @(posedge core_clk);
  endtask

  initial begin
    #400000;
    failCount++;
    endOfTest();
  end

  // ==========================================================
  // main sequence
  initial begin
    int r;
    int i;
    int n;
    int k;
    logic [5:0]  a;
    logic [15:0] last;
    logic [7:0]  ctrl;
    for (i = 0; i < 64; i++) begin
      mem[i] = {10'h2A5, i[5:0]};
      expMem[i] = {10'h2A5, i[5:0]};
    end
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    repeat (5) @(posedge core_clk);
    for (r = 0; r < 10; r++) begin
      startCmd(ROWS[r]);
      waitIdle();
      n = ROWS[r].words;
      a = ROWS[r].addr;
      for (i = 0; i < n; i++) begin
        if (ROWS[r].mode[1]) begin
          last = expMem[a];
          check(32'(rdQ[i]), 32'(last));
        end else begin
          last = ROWS[r].data + i[15:0];
          expMem[a] = last;
          check(32'(mem[a]), 32'(last));
        end
        a = (a == BURST_WRAP_ADDR) ? ADDR_FIRST : a + 6'h01;
      end
      if (ROWS[r].mode[1]) check(32'(rdQ.size()), 32'(n));
      ctrl = {ROWS[r].mode[1], 6'h00, ROWS[r].mode[0]};
      ctrl[6:1] = ROWS[r].mode[2] ? 6'(rev({10'h0, ROWS[r].addr}, 6)) : ROWS[r].addr;
      check(32'(ctrlSeen), 32'(ctrl));
      check(32'(bitCnt), 32'(8 + 16 * n));
      check(32'(cap[15:0]), 32'(ROWS[r].mode[2] ? rev(last, 16) : last));
      $display("test %0d done", r);
    end
    // reset in the middle of a burst read
    startCmd('{5'h03, 6'h02, 8'h04, 16'h0000});
    k = 0;
    while (u_spr_link_if.serialOutOe !== 1'b1 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    check(32'(u_spr_link_if.serialOutOe), 32'h1);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    check(32'(u_spr_link_if.serialOutOe), 32'h0);
    check(32'({regWr, regRd, busy, u_spr_link_if.csN}), 32'h1);
    check(32'({regAddr, regWrData}), 32'h0);
    repeat (5) @(posedge core_clk);
    $display("test reset done");
    // write aborted in the middle of the data word
    k = wrCnt;
    startCmd('{5'h00, 6'h10, 8'h01, 16'hBEEF});
    repeat (250) @(posedge core_clk);
    hostAbort <= 1'b1;
    @(posedge core_clk);
    hostAbort <= 1'b0;
    repeat (20) @(posedge core_clk);
    check(32'(wrCnt), 32'(k));
    check(32'(mem[16]), 32'(expMem[16]));
    startCmd('{5'h02, 6'h10, 8'h01, 16'h0000});
    waitIdle();
    check(32'(rdQ[0]), 32'(expMem[16]));
    $display("test abort done");
    endOfTest();
  end
endmodule
`default_nettype wire
